// ==== rtl/sfa_fifo.sv ====
/*
 * synchronous FIFO with valid/ready on both sides and registered read data.
 * assumes one clock and a synchronous active-low reset.
 */
`default_nettype none
module sfa_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // write side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // read side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    logic full;
    logic empty;
    logic doWr;
    logic doRd;

    // ==========================================
    // flags
    assign full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
    assign empty = (wrPtr == rdPtr);
    assign inReady = !full;
    assign doWr = inValid && !full;
    assign doRd = !empty && (!outValid || outReady);

    // storage
    always_ff @(posedge clk_sys) begin
        if (doWr) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end

    // write pointer
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wrPtr <= '0;
        end else if (doWr) begin
            wrPtr <= wrPtr + 1'b1;
        end
    end

    // read pointer and registered output
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rdPtr <= '0;
            outValid <= 1'b0;
            outData <= '0;
        end else if (doRd) begin
            rdPtr <= rdPtr + 1'b1;
            outValid <= 1'b1;
            outData <= mem[rdPtr[AW-1:0]];
        end else if (outReady) begin
            outValid <= 1'b0;
        end
    end
endmodule : sfa_fifo
`default_nettype wire

// ==== rtl/sfa_frame_align.sv ====
/*
 * frame align/detect: serial-to-parallel demux with byte boundary search on
 * the A1 pattern, A1/A2 frame detector, one-byte frame pulse and an output
 * FIFO for parallel bytes.
 * assumes serial_line_in is one bit per clk_sys, synchronous to it; the
 * out-of-frame strobe and test input are synchronous levels.
 */
`default_nettype none
// Summary of operation
// - recognise three A1 then three A2
// - strobe fall with test low marks outputs invalid until A2
// - boundary steered from A1 recognition
// - three A1, three A2 give frame pulse
// - pulse rises one byte after A2
// - pulse lasts exactly one byte period
// - detection disables recovery until re-armed
// - pulse every frame regardless of strobe
// - strobe fall with test low arms recovery
// - first A1 aligns, rest hold alignment
// - only first A1 after arming moves boundary
// - A1 A2 A2 conflicts; three-three criterion used
// - A1 is F6, A2 is 28
// - strobe fall with test high disables recovery
// - eight-bit bytes on divide-by-eight clock
module sfa_frame_align
    import sfa_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // line side
    input wire logic serial_line_in,
    // system control
    input wire logic out_of_frame_b,
    input wire logic frame_disable_test,
    // parallel side
    output logic byte_clock_out,
    output sfa_pkg::sfa_byte_s parallel_byte_out,
    input wire logic byteReady,
    output logic byteValid,
    output logic frame_found_pulse,
    output logic recoveryEnabled
);
    import sfa_pkg::*;

    logic [SFA_BITS-1:0] shiftReg;
    logic [SFA_PH_W-1:0] bitCount;
    logic [SFA_PH_W-1:0] bytePhase;
    logic byteStrobe;
    logic [SFA_BITS-1:0] curByte;
    logic oofPrev;
    logic oofFall;
    sfa_state_e state;
    logic dataValid;
    logic [1:0] a1Run;
    logic [1:0] a2Run;
    logic isA1;
    logic isA2;
    logic isA1Serial;
    logic frameHit;
    logic hitDelay;
    logic fifoInReady;
    logic fifoOutValid;
    sfa_byte_s fifoOut;
    sfa_byte_s fifoIn;
    logic [SFA_PH_W-1:0] next_bitCount;
    logic [SFA_PH_W-1:0] halfPoint;
    logic takeWord;
    logic a2AfterA1;

    // ==========================================
    // serial to parallel
    // shift in, leftmost bit arrives first
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            shiftReg <= SFA_BYTE_RESET;
        end else begin
            shiftReg <= {shiftReg[SFA_BITS-2:0], serial_line_in};
        end
    end

    // divide-by-eight timing generator, realigned on the first A1 in hunt
    assign isA1Serial = ({shiftReg[SFA_BITS-2:0], serial_line_in} == SFA_A1);
    always_comb begin
        next_bitCount = bitCount + 3'h1;
        if (state == SFA_HUNT && isA1Serial) begin
            next_bitCount = SFA_PH_RESET;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            bitCount <= SFA_PH_RESET;
        end else begin
            bitCount <= next_bitCount;
        end
    end

    // byte completes when counter wraps to zero
    assign byteStrobe = (next_bitCount == SFA_PH_RESET);
    assign curByte = {shiftReg[SFA_BITS-2:0], serial_line_in};
    assign halfPoint = SFA_PH_RESET + 3'h4;

    // phase held for observation of the chosen boundary
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            bytePhase <= SFA_PH_RESET;
        end else if (state == SFA_HUNT && isA1Serial) begin
            bytePhase <= bitCount;
        end
    end

    // byte clock: high for first half of each byte
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            byte_clock_out <= 1'b0;
        end else begin
            byte_clock_out <= (next_bitCount < halfPoint);
        end
    end

    // ==========================================
    // recovery control
    // strobe edge detect
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            oofPrev <= 1'b1;
        end else begin
            oofPrev <= out_of_frame_b;
        end
    end
    assign oofFall = oofPrev && !out_of_frame_b; // relies on width

    // recovery state: idle (disabled), hunt (armed), lock (aligned)
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state <= SFA_IDLE;
        end else if (oofFall) begin
            if (frame_disable_test) begin
                state <= SFA_IDLE;
            end else begin
                state <= SFA_HUNT;
            end
        end else begin
            case (state)
                SFA_HUNT: begin
                    if (isA1Serial) begin
                        state <= SFA_LOCK;
                    end
                end
                SFA_LOCK: begin
                    if (frameHit) begin
                        state <= SFA_IDLE;
                    end
                end
                default: begin
                    state <= state;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            recoveryEnabled <= 1'b0;
        end else begin
            recoveryEnabled <= (state == SFA_HUNT);
        end
    end

    // output validity: dropped by strobe fall with test low, restored at A1 to A2
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            dataValid <= 1'b0;
        end else if (oofFall && !frame_disable_test) begin
            dataValid <= 1'b0;
        end else if (byteStrobe && a2AfterA1) begin
            dataValid <= 1'b1;
        end
    end

    // ==========================================
    // frame detection
    assign isA1 = (curByte == SFA_A1);
    assign isA2 = (curByte == SFA_A2);
    // an A2 right after any A1 is the point where outputs turn valid
    assign a2AfterA1 = isA2 && (a1Run != 2'h0);

    // saturating run counters of A1 then A2 bytes
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            a1Run <= 2'h0;
            a2Run <= 2'h0;
        end else if (byteStrobe) begin
            if (isA1) begin
                a1Run <= (a1Run == SFA_RUN_MAX) ? a1Run : a1Run + 2'h1;
                a2Run <= 2'h0;
            end else if (isA2 && (a1Run == SFA_RUN_MAX)) begin
                a2Run <= (a2Run == SFA_RUN_MAX) ? a2Run : a2Run + 2'h1;
                a1Run <= (a2Run == 2'h2) ? 2'h0 : a1Run;
            end else begin
                a1Run <= 2'h0;
                a2Run <= 2'h0;
            end
        end
    end

    // third A2 after three A1 (strobe level ignored)
    assign frameHit = byteStrobe && isA2 && (a1Run == SFA_RUN_MAX)
        && (a2Run == 2'h2);

    // pulse one byte after hit, held exactly one byte
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            hitDelay <= 1'b0;
        end else if (frameHit) begin
            hitDelay <= 1'b1;
        end else if (byteStrobe) begin
            hitDelay <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            frame_found_pulse <= 1'b0;
        end else if (byteStrobe) begin
            frame_found_pulse <= hitDelay;
        end
    end

    // ==========================================
    // output FIFO
    // the first A2 byte itself already carries the valid mark
    assign fifoIn.valid = dataValid || a2AfterA1;
    // output register takes a word only when it is free or being drained
    assign takeWord = byteReady || !byteValid;
    assign fifoIn.data = curByte;

    sfa_fifo #(
        .WIDTH(SFA_WORD_W),
        .DEPTH(SFA_FIFO_DEPTH),
        .AW(SFA_FIFO_AW)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .inValid(byteStrobe),
        .inReady(fifoInReady),
        .inData(fifoIn),
        .outValid(fifoOutValid),
        .outReady(takeWord),
        .outData(fifoOut)
    );

    // registered parallel outputs
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            parallel_byte_out <= '0;
            byteValid <= 1'b0;
        end else if (takeWord) begin
            parallel_byte_out <= fifoOut;
            byteValid <= fifoOutValid;
        end
    end
endmodule : sfa_frame_align
`default_nettype wire

// ==== rtl/sfa_pkg.sv ====
/*
 * package for the frame align/detect block: framing patterns, counts and
 * the packed carrier for a parallel byte with its valid flag.
 * assumes a single clock domain (clk_sys, 40 MHz).
 */
`default_nettype none
package sfa_pkg;
    // ==========================================
    // framing patterns, leftmost bit first on the line
    localparam logic [7:0] SFA_A1 = 8'hF6;
    localparam logic [7:0] SFA_A2 = 8'h28;
    // ==========================================
    // stream geometry
    localparam int SFA_BITS = 8;
    localparam int SFA_PH_W = 3;
    localparam logic [2:0] SFA_LAST_BIT = 3'h7;
    localparam logic [2:0] SFA_PH_RESET = 3'h0;
    localparam int SFA_RUN = 3;
    localparam logic [1:0] SFA_RUN_MAX = 2'h3;
    localparam int SFA_FIFO_DEPTH = 32;
    localparam int SFA_FIFO_AW = 5;
    localparam logic [7:0] SFA_BYTE_RESET = 8'h00;
    // ==========================================
    // byte and its validity
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } sfa_byte_s;
    localparam int SFA_WORD_W = 9;
    typedef enum logic [1:0] {
        SFA_IDLE,
        SFA_HUNT,
        SFA_LOCK
    } sfa_state_e;
endpackage : sfa_pkg
`default_nettype wire

// ==== sim/sfa_frame_align_checker.sv ====
/* checker: frame pulse, recovery arming and byte clock of the frame aligner.
   assumes the top module's ports and the single clk_sys domain. */
`default_nettype none
module sfa_frame_align_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // watched ports
    input wire logic serial_line_in,
    input wire logic out_of_frame_b,
    input wire logic frame_disable_test,
    input wire logic byte_clock_out,
    input wire logic frame_found_pulse,
    input wire logic recoveryEnabled
);
    import sfa_pkg::*;
    logic [47:0] lineBits;
    logic [5:0] sinceHit;
    // ==========================================
    // serial history and age of the last full framing run
    always_ff @(posedge clk_sys) begin
        lineBits <= {lineBits[46:0], serial_line_in};
        if (!rst_b) sinceHit <= 6'h3F;
        else if (lineBits == {{3{SFA_A1}}, {3{SFA_A2}}}) sinceHit <= 6'h00;
        else if (sinceHit != 6'h3F) sinceHit <= sinceHit + 6'h01;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // ==========================================
    // properties
    a_pulse_width: assert property ($rose(frame_found_pulse) |->
        frame_found_pulse[*8] ##1 !frame_found_pulse) else $error("pulse width wrong");
    a_reset_quiet: assert property ($rose(rst_b) |->
        !frame_found_pulse && !recoveryEnabled) else $error("busy after reset");
    a_arm_on_fall: assert property ($fell(out_of_frame_b) && !frame_disable_test |->
        ##[1:3] recoveryEnabled) else $error("recovery not armed");
    a_test_disarms: assert property ($fell(out_of_frame_b) && frame_disable_test |->
        ##3 !recoveryEnabled) else $error("recovery armed in test");
    a_lock_disarms: assert property ($rose(frame_found_pulse) |->
        !recoveryEnabled) else $error("recovery still armed");
    a_pulse_after_run: assert property (sinceHit == 6'h00 |->
        ##[1:32] $rose(frame_found_pulse)) else $error("pulse missing");
    a_pulse_has_cause: assert property ($rose(frame_found_pulse) |->
        sinceHit <= 6'h20) else $error("pulse without run");
    a_byte_clock: assert property ($rose(byte_clock_out) && !recoveryEnabled
        && out_of_frame_b |-> byte_clock_out[*4] ##1 !byte_clock_out[*4])
        else $error("byte clock shape wrong");
endmodule : sfa_frame_align_checker
bind sfa_frame_align sfa_frame_align_checker u_chk (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .serial_line_in(serial_line_in),
    .out_of_frame_b(out_of_frame_b),
    .frame_disable_test(frame_disable_test),
    .byte_clock_out(byte_clock_out),
    .frame_found_pulse(frame_found_pulse),
    .recoveryEnabled(recoveryEnabled)
);
`default_nettype wire

// ==== sim/sfa_frame_align_tb.sv ====
/* testbench: serial frames, strobe control, output FIFO drain and stalls.
   assumes the checker is bound and the controller model drives the strobe. */
`default_nettype none
module sfa_frame_align_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sfa_pkg::*;
    logic clk_sys, rst_b, serialBit, fire, fdt, byteReady, stall, byteClk;
    logic byteValid, ffp, recEn, oofB, lastP;
    logic [3:0] lowBytes;
    sfa_byte_s parByte;
    sfa_byte_s q[$];
    int seed = 77;
    int bad_count = 0;
    int n_tests = 0;
    int rises = 0;
    int highCycles = 0;
    sfa_frame_align DUT (.clk_sys(clk_sys), .rst_b(rst_b), .serial_line_in(serialBit),
        .out_of_frame_b(oofB), .frame_disable_test(fdt), .byte_clock_out(byteClk),
        .parallel_byte_out(parByte), .byteReady(byteReady), .byteValid(byteValid),
        .frame_found_pulse(ffp), .recoveryEnabled(recEn));
    sfa_oof_ctrl u_ctrl (.clk_sys(clk_sys), .fire(fire), .lowBytes(lowBytes),
        .out_of_frame_b(oofB));
    // ==========================================
    // clock, consumer stalls and output monitor
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) #2 byteReady = stall ? 1'b0 : ($random(seed) % 4 != 0);
    always @(posedge clk_sys) begin
        if (byteValid === 1'b1 && byteReady) q.push_back(parByte);
        if (ffp === 1'b1) highCycles++;
        if (ffp === 1'b1 && lastP !== 1'b1) rises++;
        lastP = ffp;
    end
    // ==========================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    // filler never holds four ones in a row, so never looks like A1
    function automatic logic [7:0] fill();
        return $random(seed) & 8'h55;
    endfunction : fill
    function automatic int expect_pulses(input int nA1, input int nA2);
        return (nA1 >= 3 && nA2 >= 3) ? 1 : 0;
    endfunction : expect_pulses
    function automatic logic aligned();
        for (int i = 1; i < q.size(); i++)
            if (q[i-1].data === SFA_A1 && q[i].data === SFA_A2 && q[i].valid === 1'b1) return 1;
        return 0;
    endfunction : aligned
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk_sys);
            #2 serialBit = b[i];
        end
    endtask : send_byte
    task automatic frame(input int nA1, input int nA2, input logic arm);
        int r0;
        r0 = rises;
        q.delete();
        fire = arm;
        send_byte(fill());
        fire = 1'b0;
        repeat (4) send_byte(fill());
        repeat (nA1) send_byte(SFA_A1);
        repeat (nA2) send_byte(SFA_A2);
        repeat (6) send_byte(fill());
        check(rises - r0, expect_pulses(nA1, nA2), "pulse count");
        check(highCycles, rises * 8, "pulse length");
        check(aligned(), 1'b1, "byte alignment");
    endtask : frame
    // ==========================================
    // main sequence
    initial begin
        serialBit = 1'b0;
        fire = 1'b0;
        lowBytes = 4'h1;
        fdt = 1'b0;
        byteReady = 1'b1;
        stall = 1'b0;
        rst_b = 1'b0;
        repeat (12) @(posedge clk_sys);
        #2 rst_b = 1'b1;
        check(ffp, 1'b0, "pulse after reset");
        check(recEn, 1'b0, "armed after reset");
        frame(3, 3, 1'b1);
        frame(3, 3, 1'b0);
        frame(1, 2, 1'b0);
        fdt = 1'b1;
        frame(3, 3, 1'b1);
        check(recEn, 1'b0, "armed in test mode");
        fdt = 1'b0;
        for (int k = 0; k < 8; k++) begin
            lowBytes = 4'($random(seed));
            frame(2 + ($random(seed) & 3), 2 + ($random(seed) & 3), 1'($random(seed)));
        end
        stall = 1'b1;
        repeat (40) send_byte(fill());
        check(byteValid, 1'b1, "word held under stall");
        stall = 1'b0;
        frame(24, 24, 1'b1);
        end_sim();
    end
    initial begin
        repeat (100000) @(posedge clk_sys);
        bad_count++;
        end_sim();
    end
endmodule : sfa_frame_align_tb
`default_nettype wire

// ==== sim/sfa_oof_ctrl.sv ====
/* system framing controller model: drives the out-of-frame strobe.
   assumes fire is raised by the bench just after a clk_sys edge. */
`default_nettype none
module sfa_oof_ctrl (
    // clock
    input wire logic clk_sys,
    // request from the bench
    input wire logic fire,
    input wire logic [3:0] lowBytes,
    // strobe to the device
    output logic out_of_frame_b
);
    timeunit 1ns;
    timeprecision 100ps;
    int left = 0;
    initial out_of_frame_b = 1'b1;
    // hold the strobe low for whole bytes, never under one
    always @(posedge clk_sys) begin
        if (fire && left == 0) begin
            #2 out_of_frame_b = 1'b0;
            left = (lowBytes == 4'h0 ? 1 : lowBytes) * 8;
        end else if (left > 0) begin
            left = left - 1;
            if (left == 0) #2 out_of_frame_b = 1'b1;
        end
    end
endmodule : sfa_oof_ctrl
`default_nettype wire
